// ===== hw/axis_program_step_teach_offset.sv
// per-axis single-step program run, teach-in recording and coordinate shift
// assumes an AXI4-Lite master on CLK_IN; other axis status arrives as levels
//
// Function
// - one movement or dwell per enter, then halt
// - start locates program, runs to first movement
// - stop ends single-step anytime, even mid-movement
// - flying-change chain runs as one step
// - halt beats flying change, splits there
// - offsets run after start, movement, halt
// - halt beside movement needs no extra enter
// - recording allows only jog, incremental approaches and recording off
// - recording without positions yields empty program
// - enter when finished appends actual position
// - recording off appends end, registers program
// - sequential numbering, full speed, no auxiliaries
// - recording on needs data, home, memory, free number
// - oversize program ends recording automatically
// - absolute shift assigns coordinate without motion
// - oversized shift parameter gives illegal distance
// - shifted range overflow gives range error
// - program end cancels program offsets only
// - shifts accumulate, need data, no home
// - new machine data clears coordinate shift, keeps program offsets
// - relative shift forwards negative, adds up
// - clear-shift drops total shift from position at once, clears coordinate shift, keeps program offsets
`default_nettype none
module axis_program_step_teach_offset
	import axis_step_teach_pkg::*;
#(
	parameter int MEM_DEPTH = 512,
	parameter int PROG_NUMS = 16
) (
	input  wire logic        CLK_IN,
	input  wire logic        RSTN_IN,
	input  wire logic        CE_IN,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        MD_VALID_IN,
	input  wire logic        MD_LOAD_IN,
	input  wire logic        HOME_SET_IN,
	input  wire logic        OTHER_BUSY_IN,
	output logic             RECORD_ACTIVE_OUT
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam int PW = $clog2(PROG_NUMS);
	localparam int MAX_STMTS = MAX_PROG_CHARS / CHARS_PER_STMT;

	if (MEM_DEPTH < 4 || PROG_NUMS < 2 || PROG_NUMS > 256) begin : g_param_chk
		$error("unsupported parameters");
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0]   mem_q [MEM_DEPTH];
	logic [AW-1:0] dir_start_q [PROG_NUMS];
	logic          dir_used_q [PROG_NUMS];
	logic [AW-1:0] free_q;

	logic signed [31:0] pos_q, shift_q, prog_off_q, param_q;
	logic [3:0]  err_q;
	logic [4:0]  mode_q;
	logic        rec_q, stored_q;
	logic [PW-1:0] rec_prog_q;
	logic [AW-1:0] rec_cnt_q, pc_q, stmt_idx_q;
	logic        fly_q;
	step_state_t ss_q;
	logic [15:0] move_cnt_q;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	logic aw_hold_q, w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic        wr_go;
	assign S_AXI_AWREADY = !aw_hold_q && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_hold_q && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign wr_go = aw_hold_q && w_hold_q && !S_AXI_BVALID;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else if (CE_IN) begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (awaddr_q == REG_CMD || awaddr_q == REG_PARAM || awaddr_q == REG_STMT_IDX)
					? 2'h0 : 2'h2;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	wire cmd_wr   = wr_go && awaddr_q == REG_CMD;
	wire [4:0] c_mode = wdata_q[CMD_MODE_LSB +: CMD_MODE_W];
	wire [2:0] c_op   = wdata_q[CMD_OP_LSB +: CMD_OP_W];
	wire [PW-1:0] c_prog = wdata_q[CMD_PROG_LSB +: PW];

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			param_q <= 32'sh0;
			stmt_idx_q <= '0;
		end else if (CE_IN && wr_go) begin
			if (awaddr_q == REG_PARAM)
				param_q <= wdata_q;
			if (awaddr_q == REG_STMT_IDX)
				stmt_idx_q <= wdata_q[AW-1:0];
		end
	end

	logic [31:0] rd_d;
	logic [1:0]  rresp_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		rresp_d = 2'h0;
		case (S_AXI_ARADDR)
			REG_PARAM:    rd_d = param_q;
			REG_STATUS: begin
				rd_d[ST_FINISHED] = (ss_q == SS_IDLE || ss_q == SS_WAIT);
				rd_d[ST_RUNNING]  = (ss_q == SS_MOVE || ss_q == SS_EXEC || ss_q == SS_FETCH);
				rd_d[ST_WAIT_ENT] = (ss_q == SS_WAIT);
				rd_d[ST_RECORD]   = rec_q;
				rd_d[ST_STORED]   = stored_q;
				rd_d[ST_MD_VALID] = MD_VALID_IN;
				rd_d[ST_HOME_SET] = HOME_SET_IN;
				rd_d[ST_DIR_FULL] = (free_q >= AW'(MEM_DEPTH - 2));
			end
			REG_ERROR:    rd_d = {28'h0, err_q};
			REG_POS:      rd_d = pos_q;
			REG_SHIFT:    rd_d = shift_q + prog_off_q;
			REG_PROG:     rd_d = 32'(pc_q);
			REG_STMT_IDX: rd_d = 32'(stmt_idx_q);
			REG_STMT_RD:  rd_d = mem_q[stmt_idx_q];
			REG_MODE_RD:  rd_d = {27'h0, mode_q};
			REG_CMD:      rd_d = 32'h0000_0000;
			default:      rresp_d = 2'h2;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= 2'h0;
		end else if (CE_IN) begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_d;
				S_AXI_RRESP <= rresp_d;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire rec_allowed = c_mode == MODE_JOG1 || c_mode == MODE_JOG2 || c_mode == MODE_JOG3
		|| c_mode == MODE_INC_ABS || c_mode == MODE_INC_REL || c_mode == MODE_REC_OFF;
	wire cmd_ok   = cmd_wr && (!rec_q || rec_allowed);
	wire cmd_deny = cmd_wr && rec_q && !rec_allowed;
	wire is_enter = cmd_ok && c_op == OP_ENTER;
	wire is_stop  = cmd_ok && c_op == OP_STOP;
	wire is_start = cmd_ok && (c_op == OP_START || c_op == OP_FWD || c_op == OP_BWD);
	wire axis_finished = (ss_q == SS_IDLE);

	wire rec_req = is_start && c_mode == MODE_REC_ON && !rec_q;
	wire rec_ok  = MD_VALID_IN && HOME_SET_IN && (free_q < AW'(MEM_DEPTH - 2))
		&& !dir_used_q[c_prog] && !OTHER_BUSY_IN;
	wire rec_store = rec_q && is_enter && axis_finished
		&& (c_mode == MODE_JOG1 || c_mode == MODE_JOG2 || c_mode == MODE_JOG3
		|| c_mode == MODE_INC_ABS || c_mode == MODE_INC_REL);
	wire rec_full  = rec_cnt_q >= AW'(MAX_STMTS - 1) || free_q >= AW'(MEM_DEPTH - 2);
	wire rec_close = rec_q && ((is_start && c_mode == MODE_REC_OFF) || (rec_store && rec_full));

	// ----------------------------------------------------------------
	// shift arithmetic
	// ----------------------------------------------------------------
	logic signed [32:0] delta;
	always_comb begin
		delta = 33'sh0;
		if (c_mode == MODE_ABS_SHIFT)
			delta = 33'(param_q) - 33'(pos_q);
		else if (c_op == OP_BWD)
			delta = 33'(param_q);
		else
			delta = -33'(param_q);
	end
	wire signed [32:0] new_pos = 33'(pos_q) + delta;
	wire signed [32:0] new_shift = 33'(shift_q) + delta;
	wire shift_cmd  = is_start && (c_mode == MODE_ABS_SHIFT || c_mode == MODE_REL_SHIFT) && axis_finished;
	wire dist_bad   = param_q > MAX_DIST || param_q < -MAX_DIST;
	wire range_bad  = new_pos > 33'(RANGE_LIMIT) || new_pos < -33'(RANGE_LIMIT)
		|| new_shift > 33'(RANGE_LIMIT) || new_shift < -33'(RANGE_LIMIT);

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			pos_q <= 32'sh0;
			shift_q <= 32'sh0;
		end else if (CE_IN) begin
			if (MD_LOAD_IN) begin
				pos_q <= pos_q - shift_q;
				shift_q <= 32'sh0;
			end else if (shift_cmd && MD_VALID_IN && !dist_bad && !range_bad) begin
				pos_q <= new_pos[31:0];
				shift_q <= new_shift[31:0];
			end else if (is_start && c_mode == MODE_CLR_SHIFT && axis_finished) begin
				pos_q <= pos_q - shift_q - prog_off_q;
				shift_q <= 32'sh0;
			end else if (ss_q == SS_MOVE && move_cnt_q == 16'h0001) begin
				pos_q <= 32'(signed'(mem_q[pc_q][STMT_VAL_W-1:0])) + prog_off_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// errors and mode
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			err_q <= ERR_NONE;
			mode_q <= MODE_NONE;
		end else if (CE_IN) begin
			if (cmd_ok)
				mode_q <= c_mode;
			if (cmd_deny)
				err_q <= ERR_MODE_DENY;
			else if (rec_req && !rec_ok)
				err_q <= ERR_REC_DENY;
			else if (shift_cmd && dist_bad)
				err_q <= ERR_ILL_DIST;
			else if (shift_cmd && range_bad)
				err_q <= ERR_RANGE;
			else if (is_start && c_mode == MODE_SINGLE && !dir_used_q[c_prog])
				err_q <= ERR_NO_PROG;
			else if (cmd_ok)
				err_q <= ERR_NONE;
		end
	end

	// ----------------------------------------------------------------
	// recording
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			rec_q <= 1'b0;
			stored_q <= 1'b0;
			rec_prog_q <= '0;
			rec_cnt_q <= '0;
			free_q <= '0;
			for (int i = 0; i < PROG_NUMS; i++) begin
				dir_used_q[i] <= 1'b0;
				dir_start_q[i] <= '0;
			end
		end else if (CE_IN) begin
			if (cmd_ok)
				stored_q <= 1'b0;
			if (rec_req && rec_ok) begin
				rec_q <= 1'b1;
				rec_prog_q <= c_prog;
				rec_cnt_q <= AW'(FIRST_STMT_NUM - 1);
				dir_start_q[c_prog] <= free_q;
			end else if (rec_req) begin
				rec_q <= 1'b0;
			end
			if (rec_store) begin
				mem_q[free_q] <= {KIND_MOVE, 2'b00, pos_q[STMT_VAL_W-1:0]};
				free_q <= free_q + 1'b1;
				rec_cnt_q <= rec_cnt_q + 1'b1;
				stored_q <= 1'b1;
			end
			if (rec_close) begin
				mem_q[rec_store ? AW'(free_q + 1'b1) : free_q] <= {KIND_END, 28'h0};
				free_q <= free_q + (rec_store ? AW'(2) : AW'(1));
				dir_used_q[rec_prog_q] <= 1'b1;
				rec_q <= 1'b0;
			end
		end
	end
	assign RECORD_ACTIVE_OUT = rec_q;

	// ----------------------------------------------------------------
	// single-step sequencer
	// ----------------------------------------------------------------
	wire [31:0] stmt = mem_q[pc_q];
	wire [3:0]  kind = stmt[STMT_KIND_LSB +: 4];
	wire        halt_b = stmt[STMT_HALT_BIT];
	wire        fly_b  = stmt[STMT_FLY_BIT] && !halt_b;

	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ss_q <= SS_IDLE;
			pc_q <= '0;
			fly_q <= 1'b0;
			move_cnt_q <= 16'h0000;
			prog_off_q <= 32'sh0;
		end else if (CE_IN) begin
			if (is_stop && mode_q == MODE_SINGLE) begin
				ss_q <= SS_IDLE;
				move_cnt_q <= 16'h0000;
			end else begin
				case (ss_q)
					SS_IDLE: begin
						if (is_start && c_mode == MODE_SINGLE && dir_used_q[c_prog] && MD_VALID_IN) begin
							pc_q <= dir_start_q[c_prog];
							fly_q <= 1'b0;
							ss_q <= SS_FETCH;
						end
					end
					SS_FETCH: begin
						ss_q <= SS_EXEC;
					end
					SS_EXEC: begin
						case (kind)
							KIND_OFFSET: begin
								prog_off_q <= prog_off_q + 32'(signed'(stmt[STMT_VAL_W-1:0]));
								pc_q <= pc_q + 1'b1;
								if (halt_b)
									ss_q <= SS_WAIT;
							end
							KIND_HALT: begin
								pc_q <= pc_q + 1'b1;
								ss_q <= SS_WAIT;
							end
							KIND_MOVE, KIND_DWELL: begin
								if (fly_q)
									ss_q <= SS_MOVE;
								else
									ss_q <= SS_WAIT;
							end
							KIND_END: begin
								prog_off_q <= 32'sh0;
								ss_q <= SS_IDLE;
							end
							default: begin
								pc_q <= pc_q + 1'b1;
							end
						endcase
					end
					SS_WAIT: begin
						if (is_enter && mode_q == MODE_SINGLE) begin
							if (kind == KIND_MOVE || kind == KIND_DWELL) begin
								move_cnt_q <= 16'(MOVE_CYCLES);
								ss_q <= SS_MOVE;
							end else begin
								ss_q <= SS_EXEC;
							end
						end
					end
					SS_MOVE: begin
						if (move_cnt_q == 16'h0000) begin
							move_cnt_q <= 16'(MOVE_CYCLES);
						end else if (move_cnt_q == 16'h0001) begin
							move_cnt_q <= 16'h0000;
							fly_q <= fly_b;
							pc_q <= pc_q + 1'b1;
							ss_q <= SS_EXEC;
						end else begin
							move_cnt_q <= move_cnt_q - 1'b1;
						end
					end
					default: ss_q <= SS_IDLE;
				endcase
			end
		end
	end
endmodule : axis_program_step_teach_offset
`default_nettype wire

// ===== hw/axis_step_teach_pkg.sv
// constants for the per-axis step, teach-in and coordinate shift logic
// assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data
package axis_step_teach_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_PARAM    = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h08;
	localparam logic [7:0] REG_ERROR    = 8'h0C;
	localparam logic [7:0] REG_POS      = 8'h10;
	localparam logic [7:0] REG_SHIFT    = 8'h14;
	localparam logic [7:0] REG_PROG     = 8'h18;
	localparam logic [7:0] REG_STMT_IDX = 8'h1C;
	localparam logic [7:0] REG_STMT_RD  = 8'h20;
	localparam logic [7:0] REG_MODE_RD  = 8'h24;
	// ----------------------------------------------------------------
	// command register fields
	// ----------------------------------------------------------------
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_MODE_W   = 5;
	localparam int CMD_OP_LSB   = 8;
	localparam int CMD_OP_W     = 3;
	localparam int CMD_PROG_LSB = 16;
	localparam int CMD_PROG_W   = 8;
	// ----------------------------------------------------------------
	// mode numbers
	// ----------------------------------------------------------------
	localparam logic [4:0] MODE_NONE       = 5'h00;
	localparam logic [4:0] MODE_JOG1       = 5'h01;
	localparam logic [4:0] MODE_JOG2       = 5'h02;
	localparam logic [4:0] MODE_JOG3       = 5'h03;
	localparam logic [4:0] MODE_CALIBRATE  = 5'h05;
	localparam logic [4:0] MODE_INC_ABS    = 5'h06;
	localparam logic [4:0] MODE_INC_REL    = 5'h07;
	localparam logic [4:0] MODE_SINGLE     = 5'h09;
	localparam logic [4:0] MODE_REC_ON     = 5'h0A;
	localparam logic [4:0] MODE_REC_OFF    = 5'h0B;
	localparam logic [4:0] MODE_ABS_SHIFT  = 5'h0C;
	localparam logic [4:0] MODE_REL_SHIFT  = 5'h0D;
	localparam logic [4:0] MODE_CLR_SHIFT  = 5'h0E;
	// ----------------------------------------------------------------
	// operations
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_START = 3'h1;
	localparam logic [2:0] OP_STOP  = 3'h2;
	localparam logic [2:0] OP_ENTER = 3'h3;
	localparam logic [2:0] OP_FWD   = 3'h4;
	localparam logic [2:0] OP_BWD   = 3'h5;
	// ----------------------------------------------------------------
	// error codes
	// ----------------------------------------------------------------
	localparam logic [3:0] ERR_NONE      = 4'h0;
	localparam logic [3:0] ERR_ILL_DIST  = 4'h1;
	localparam logic [3:0] ERR_RANGE     = 4'h2;
	localparam logic [3:0] ERR_REC_DENY  = 4'h3;
	localparam logic [3:0] ERR_MODE_DENY = 4'h4;
	localparam logic [3:0] ERR_NO_PROG   = 4'h5;
	// ----------------------------------------------------------------
	// statement word layout: kind in the top nibble, value below
	// ----------------------------------------------------------------
	localparam int          STMT_KIND_LSB = 28;
	localparam logic [3:0]  KIND_MOVE     = 4'h1;
	localparam logic [3:0]  KIND_DWELL    = 4'h2;
	localparam logic [3:0]  KIND_OFFSET   = 4'h3;
	localparam logic [3:0]  KIND_END      = 4'h4;
	localparam logic [3:0]  KIND_HALT     = 4'h5;
	localparam int          STMT_FLY_BIT  = 27;
	localparam int          STMT_HALT_BIT = 26;
	localparam int          STMT_VAL_W    = 26;
	// ----------------------------------------------------------------
	// limits and sizes
	// ----------------------------------------------------------------
	localparam logic signed [31:0] MAX_DIST       = 32'sh0262_5A00;
	localparam logic signed [31:0] RANGE_LIMIT    = 32'sh0262_5A00;
	localparam int                 MAX_PROG_CHARS = 10000;
	localparam int                 CHARS_PER_STMT = 20;
	localparam int                 FIRST_STMT_NUM = 1;
	localparam logic [7:0]         FULL_SPEED_PCT = 8'h64;
	localparam int                 MOVE_TIME_NS   = 1000;
	localparam int                 CLK_PERIOD_NS  = 5;
	localparam int                 MOVE_CYCLES    = (MOVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// status bits
	// ----------------------------------------------------------------
	localparam int ST_FINISHED = 0;
	localparam int ST_RUNNING  = 1;
	localparam int ST_WAIT_ENT = 2;
	localparam int ST_RECORD   = 3;
	localparam int ST_STORED   = 4;
	localparam int ST_MD_VALID = 5;
	localparam int ST_HOME_SET = 6;
	localparam int ST_DIR_FULL = 7;

	typedef enum logic [2:0] {
		SS_IDLE  = 3'b000,
		SS_FETCH = 3'b001,
		SS_EXEC  = 3'b010,
		SS_WAIT  = 3'b011,
		SS_MOVE  = 3'b100
	} step_state_t;
endpackage : axis_step_teach_pkg

// ===== tb/axis_ctrl_model.sv
// controller model: AXI4-Lite master with word read and write tasks
// assumes a slave with 8-bit addresses and 32-bit data
`default_nettype none
module axis_ctrl_model (
	input  wire logic        clk_in,
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic        bvalid_in,
	input  wire logic [1:0]  bresp_in,
	output logic             bready_out,
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic        rvalid_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	output logic             rready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		awaddr_out <= a;
		wdata_out <= d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awready_in) awvalid_out <= 1'b0;
			if (wready_in) wvalid_out <= 1'b0;
		end while (!bvalid_in);
		r = bresp_in;
		bready_out <= 1'b0;
		awaddr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arready_in) arvalid_out <= 1'b0;
		end while (!rvalid_in);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
		araddr_out <= ~a;
	endtask : rd
endmodule : axis_ctrl_model
`default_nettype wire

// ===== tb/axis_program_step_teach_offset_tb.sv
// testbench for the step, teach-in and coordinate shift block
// assumes the controller model and the bound port checker
`default_nettype none
module axis_program_step_teach_offset_tb
	import axis_step_teach_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, ce, md_valid, md_load, home_set, other_busy, rec_act;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, v, pos0;
	logic [1:0]  bresp, rresp, r;
	int          num_errors = 0, n_compared = 0;
	axis_ctrl_model ctrl_i (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid), .bresp_in(bresp),
		.bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
		.rvalid_in(rvalid), .rdata_in(rdata), .rresp_in(rresp), .rready_out(rready));
	axis_program_step_teach_offset axis_program_step_teach_offset_i (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .MD_VALID_IN(md_valid), .MD_LOAD_IN(md_load), .HOME_SET_IN(home_set),
		.OTHER_BUSY_IN(other_busy), .RECORD_ACTIVE_OUT(rec_act));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ctrl_i.rd(a, v, r);
		chk(nm, e, v & m);
	endtask : rdc
	task automatic cmd(input logic [4:0] m, input logic [2:0] op, input logic [31:0] p);
		ctrl_i.wr(REG_PARAM, p, r);
		ctrl_i.wr(REG_CMD, {8'h00, 8'h07, 5'h00, op, 3'h0, m}, r);
	endtask : cmd
	task automatic wait_st(input int b, input logic e);
		for (int i = 0; i < 150; i++) begin
			ctrl_i.rd(REG_STATUS, v, r);
			if (v[b] === e) break;
		end
		chk("status bit", {31'h0, e}, {31'h0, v[b]});
	endtask : wait_st
	task automatic end_sim;
		if (num_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#(5 * 60000);
		num_errors++;
		end_sim();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{rstn, md_load, other_busy} = 3'h0;
		{ce, md_valid, home_set} = 3'h7;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rdc("status", REG_STATUS, 32'h68, 32'h60);
		ctrl_i.rd(8'h40, v, r);
		chk("unmapped resp", 32'h2, {30'h0, r});
		ctrl_i.wr(REG_STATUS, 32'h0, r);
		chk("read-only resp", 32'h2, {30'h0, r});
		other_busy <= 1'b1;
		cmd(MODE_REC_ON, OP_START, 32'h0);
		chk("record active", 32'h0, 32'(rec_act));
		rdc("error", REG_ERROR, 32'hF, {28'h0, ERR_REC_DENY});
		other_busy <= 1'b0;
		cmd(MODE_REC_ON, OP_START, 32'h0);
		chk("record active", 32'h1, 32'(rec_act));
		cmd(MODE_ABS_SHIFT, OP_START, 32'h190);
		rdc("error", REG_ERROR, 32'hF, {28'h0, ERR_MODE_DENY});
		rdc("shift", REG_SHIFT, ~32'h0, 32'h0);
		ctrl_i.rd(REG_POS, pos0, r);
		repeat (2) cmd(MODE_JOG1, OP_ENTER, 32'h0);
		rdc("stored", REG_STATUS, 32'h10, 32'h10);
		for (int i = 0; i < 2; i++) begin
			ctrl_i.wr(REG_STMT_IDX, i, r);
			rdc("stmt", REG_STMT_RD, ~32'h0, {KIND_MOVE, 2'b00, pos0[25:0]});
		end
		cmd(MODE_REC_OFF, OP_START, 32'h0);
		chk("record active", 32'h0, 32'(rec_act));
		ctrl_i.wr(REG_STMT_IDX, 32'h2, r);
		rdc("end stmt", REG_STMT_RD, 32'hF000_0000, {KIND_END, 28'h0});
		cmd(MODE_SINGLE, OP_START, 32'h0);
		wait_st(ST_WAIT_ENT, 1'b1);
		cmd(MODE_SINGLE, OP_ENTER, 32'h0);
		rdc("running", REG_STATUS, 32'h2, 32'h2);
		wait_st(ST_WAIT_ENT, 1'b1);
		cmd(MODE_SINGLE, OP_ENTER, 32'h0);
		cmd(MODE_SINGLE, OP_STOP, 32'h0);
		rdc("running", REG_STATUS, 32'h2, 32'h0);
		rdc("waiting", REG_STATUS, 32'h4, 32'h0);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		ctrl_i.rd(REG_POS, pos0, r);
		cmd(MODE_ABS_SHIFT, OP_START, 32'h190);
		rdc("pos", REG_POS, ~32'h0, 32'h190);
		rdc("shift", REG_SHIFT, ~32'h0, 32'h190 - pos0);
		cmd(MODE_REL_SHIFT, OP_FWD, 32'h32);
		rdc("pos", REG_POS, ~32'h0, 32'h15E);
		cmd(MODE_REL_SHIFT, OP_BWD, -32'sd50);
		rdc("pos", REG_POS, ~32'h0, 32'h12C);
		rdc("shift", REG_SHIFT, ~32'h0, 32'h12C - pos0);
		cmd(MODE_ABS_SHIFT, OP_START, MAX_DIST + 1);
		rdc("error", REG_ERROR, 32'hF, {28'h0, ERR_ILL_DIST});
		rdc("pos", REG_POS, ~32'h0, 32'h12C);
		cmd(MODE_REL_SHIFT, OP_BWD, MAX_DIST);
		rdc("error", REG_ERROR, 32'hF, {28'h0, ERR_RANGE});
		cmd(MODE_CLR_SHIFT, OP_START, 32'h0);
		rdc("shift", REG_SHIFT, ~32'h0, 32'h0);
		rdc("pos", REG_POS, ~32'h0, pos0);
		cmd(MODE_ABS_SHIFT, OP_START, 32'h190);
		md_load <= 1'b1;
		@(posedge clk);
		md_load <= 1'b0;
		rdc("shift", REG_SHIFT, ~32'h0, 32'h0);
		end_sim();
	end
endmodule : axis_program_step_teach_offset_tb
`default_nettype wire

// ===== tb/axis_step_teach_sva.sv
// port checker for the step, teach-in and shift block
// assumes binding onto axis_program_step_teach_offset, one clock domain
`default_nettype none
module axis_step_teach_sva (
	input wire logic        CLK_IN,
	input wire logic        RSTN_IN,
	input wire logic        CE_IN,
	input wire logic [7:0]  S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        MD_VALID_IN,
	input wire logic        HOME_SET_IN,
	input wire logic        OTHER_BUSY_IN,
	input wire logic        RECORD_ACTIVE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [7:0] ar_q;
	always_ff @(posedge CLK_IN) begin
		if (S_AXI_ARVALID && S_AXI_ARREADY)
			ar_q <= S_AXI_ARADDR;
	end
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("bresp dropped");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("rdata dropped");
	AST_AR_READY: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
		else $error("arready wrong");
	AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("rvalid late");
	AST_B_LAT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
		else $error("bvalid late");
	AST_RD_UNMAPPED: assert property (S_AXI_RVALID && ar_q > 8'h24 |-> S_AXI_RRESP == 2'h2)
		else $error("no slverr");
	AST_REC_NEEDS: assert property ($rose(RECORD_ACTIVE_OUT) |->
		$past(MD_VALID_IN) && $past(HOME_SET_IN) && !$past(OTHER_BUSY_IN))
		else $error("bad record start");
	AST_CE_FREEZE: assert property (!CE_IN |=> $stable(RECORD_ACTIVE_OUT) && $stable(S_AXI_BVALID))
		else $error("moved while frozen");
	AST_RST_IDLE: assert property (disable iff (1'b0) !RSTN_IN && CE_IN |=>
		!S_AXI_BVALID && !S_AXI_RVALID && !RECORD_ACTIVE_OUT)
		else $error("busy after reset");
	cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
	cover property ($rose(RECORD_ACTIVE_OUT));
	cover property ($fell(RECORD_ACTIVE_OUT));
endmodule : axis_step_teach_sva
bind axis_program_step_teach_offset axis_step_teach_sva axis_step_teach_sva_i (.CLK_IN, .RSTN_IN, .CE_IN,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
	.S_AXI_BRESP, .MD_VALID_IN, .HOME_SET_IN, .OTHER_BUSY_IN, .RECORD_ACTIVE_OUT);
`default_nettype wire
